// [rtl/secl_pkg.sv]
package secl_pkg;

  // Geometry of the one supported part: 256 words of 16 bits
  localparam int SECL_AW = 8;
  localparam int SECL_CFG_N = 3;
  localparam int SECL_SR_W = 26;

  // Byte offsets seen by the host, and the validity signature
  localparam logic [15:0] SECL_SIG_OFFSET = 16'h2000;
  localparam logic [15:0] SECL_MASK_OFFSET = 16'h2010;
  localparam logic [15:0] SECL_SIGNATURE = 16'ha55a;
  // A released, pulled-up data line reads as all ones
  localparam logic [15:0] SECL_BLANK_WORD = 16'hffff;

  // Values used when the signature is missing, and the word index of the first configuration word
  localparam logic [15:0] SECL_MASK_DEFAULT = 16'h0000;
  localparam logic [SECL_CFG_N-1:0][15:0] SECL_CFG_DEFAULT =
    {16'h0003, 16'h0002, 16'h0001};
  localparam logic [7:0] SECL_CFG_BASE = 8'h01;

  // Load sequence steps
  localparam logic [2:0] SECL_STEP_SIG = 3'h0;
  localparam logic [2:0] SECL_STEP_MASK = 3'h1;
  localparam logic [2:0] SECL_STEP_CFG0 = 3'h2;
  localparam logic [2:0] SECL_STEP_LAST = 3'h4;

  // Serial frame: start, opcode, address, then data
  localparam logic [4:0] SECL_HDR_BITS = 5'h0a;
  localparam logic [4:0] SECL_DATA_BITS = 5'h10;

  typedef enum logic [3:0] {
    SECL_M_START = 4'h0,
    SECL_M_ISSUE = 4'h1,
    SECL_M_WAIT  = 4'h3,
    SECL_M_READY = 4'h2
  } secl_mstate_t;

  typedef enum logic [2:0] {
    SECL_L_IDLE = 3'h0,
    SECL_L_HDR  = 3'h1,
    SECL_L_DATA = 3'h3,
    SECL_L_DONE = 3'h2
  } secl_lstate_t;

  typedef struct packed {
    logic               we;
    logic [SECL_AW-1:0] addr;
    logic [15:0]        wdata;
  } secl_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } secl_host_req_t;

  typedef struct packed {
    logic        ack;
    logic        denied;
    logic [31:0] rdata;
  } secl_host_rsp_t;

  typedef struct packed {
    logic                         valid;
    logic                         present;
    logic                         sig_ok;
    logic [15:0]                  mask;
    logic [SECL_CFG_N-1:0][15:0]  words;
  } secl_cfg_t;

  // Host byte offset to word index; upper bits wrap on the part
  function automatic logic [SECL_AW-1:0] secl_word_index(
    input logic [15:0] off
  );
    return off[SECL_AW+1:2];
  endfunction

  // Two mask bits per region, region taken from the index top bits
  function automatic logic secl_allowed(
    input logic [15:0]        mask,
    input logic [SECL_AW-1:0] idx,
    input logic               we
  );
    logic [1:0] sub;
    sub = mask[{idx[SECL_AW-1 -: 3], 1'b0} +: 2];
    case (sub)
      2'b00:   return 1'b1;
      2'b01:   return we;
      2'b10:   return !we;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// [rtl/secl_link.sv]
`timescale 1ns/10ps
module secl_link (
  input  wire logic                 link_clk,
  input  wire logic                 sys_rst,
  input  wire secl_pkg::secl_cmd_t  cmd,
  input  wire logic                 req_tgl,
  output logic                      ack_tgl,
  output logic [15:0]               rdata,
  output logic                      eeprom_serial_clock,
  output logic                      eeprom_serial_data_level,
  output logic                      eeprom_serial_data_oe,
  input  wire logic                 eeprom_serial_data_sense
);
  import secl_pkg::*;

  typedef struct packed {
    logic                 rst_s1;
    logic                 rst_s2;
    logic                 req_s1;
    logic                 req_s2;
    logic                 req_seen;
    logic                 ack_tgl;
    secl_lstate_t         state;
    logic [1:0]           phase;
    logic [4:0]           bitcnt;
    logic [SECL_SR_W-1:0] shreg;
    logic                 we;
    logic [15:0]          rdata;
    logic                 sck;
    logic                 sda;
    logic                 oe;
    logic                 sda_s1;
    logic                 sda_s2;
  } secl_link_st_t;

  secl_link_st_t st_r;
  secl_link_st_t st_nxt;

  // Frame engine; one bit is four link clocks, clock high in the last two
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_s1 = sys_rst;
    st_nxt.rst_s2 = st_r.rst_s1;
    st_nxt.req_s1 = req_tgl;
    st_nxt.req_s2 = st_r.req_s1;
    st_nxt.sda_s1 = eeprom_serial_data_sense;
    st_nxt.sda_s2 = st_r.sda_s1;
    case (st_r.state)
      SECL_L_IDLE: begin
        st_nxt.sck = 1'b0;
        st_nxt.phase = 2'h0;
        // The command word is held still by the sender until the ack
        if (st_r.req_s2 != st_r.req_seen) begin
          st_nxt.req_seen = st_r.req_s2;
          st_nxt.we = cmd.we;
          st_nxt.shreg = {1'b1, ~cmd.we, cmd.addr, cmd.wdata};
          st_nxt.bitcnt = 5'h0;
          st_nxt.oe = 1'b1;
          st_nxt.state = SECL_L_HDR;
        end
      end
      SECL_L_HDR, SECL_L_DATA: begin
        st_nxt.phase = st_r.phase + 2'h1;
        st_nxt.sck = st_nxt.phase[1];
        if (st_r.phase == 2'h0) begin
          st_nxt.oe = (st_r.state == SECL_L_HDR) || st_r.we;
          st_nxt.sda = st_r.shreg[SECL_SR_W-1];
          st_nxt.shreg = {st_r.shreg[SECL_SR_W-2:0], 1'b0};
        end
        if (st_r.phase == 2'h3) begin
          st_nxt.bitcnt = st_r.bitcnt + 5'h1;
          // Sampled late in the high half, after the two-stage sync
          if (st_r.state == SECL_L_DATA && !st_r.we) begin
            st_nxt.rdata = {st_r.rdata[14:0], st_r.sda_s2};
          end
          if (st_r.state == SECL_L_HDR &&
              st_r.bitcnt == SECL_HDR_BITS - 5'h1) begin
            st_nxt.state = SECL_L_DATA;
            st_nxt.bitcnt = 5'h0;
          end else if (st_r.state == SECL_L_DATA &&
                       st_r.bitcnt == SECL_DATA_BITS - 5'h1) begin
            st_nxt.state = SECL_L_DONE;
          end
        end
      end
      SECL_L_DONE: begin
        st_nxt.sck = 1'b0;
        st_nxt.oe = 1'b0;
        st_nxt.ack_tgl = ~st_r.ack_tgl;
        st_nxt.state = SECL_L_IDLE;
      end
      default: st_nxt.state = SECL_L_IDLE;
    endcase
    // Reset arrives from the other domain through the two sync stages
    if (st_r.rst_s2) begin
      st_nxt = '0;
      st_nxt.rst_s1 = sys_rst;
      st_nxt.rst_s2 = st_r.rst_s1;
    end
  end

  // State register
  always_ff @(posedge link_clk) begin
    st_r <= st_nxt;
  end

  assign ack_tgl = st_r.ack_tgl;
  assign rdata = st_r.rdata;
  assign eeprom_serial_clock = st_r.sck;
  assign eeprom_serial_data_level = st_r.sda;
  assign eeprom_serial_data_oe = st_r.oe;

  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (st_r.rst_s2);

  property p_hdr_drives;
    st_r.state == SECL_L_HDR |-> st_r.oe;
  endproperty
  a_hdr_drives: assert property (p_hdr_drives)
    else $error("data line not driven during header");

  property p_read_released;
    st_r.state == SECL_L_DATA && !st_r.we && st_r.phase != 2'h0
      |-> !st_r.oe;
  endproperty
  a_read_released: assert property (p_read_released)
    else $error("data line driven while part answers");

  property p_clock_shape;
    st_r.state == SECL_L_HDR && st_r.phase == 2'h1
      |=> st_r.sck [*2] ##1 !st_r.sck;
  endproperty
  a_clock_shape: assert property (p_clock_shape)
    else $error("serial clock high time wrong");

  property p_read_frame;
    st_r.state == SECL_L_DATA && !st_r.we ##1 st_r.state == SECL_L_DONE;
  endproperty
  c_read_frame: cover property (p_read_frame);

endmodule

// [rtl/secl_loader.sv]
`timescale 1ns/10ps
module secl_loader (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    link_clk,
  input  wire secl_pkg::secl_host_req_t host_req,
  output logic                         host_ready,
  output secl_pkg::secl_host_rsp_t     host_rsp,
  output secl_pkg::secl_cfg_t          cfg,
  input  wire logic                    wp_gpio_sel,
  input  wire logic                    gpio_level,
  output logic                         eeprom_write_protect,
  output logic                         eeprom_serial_clock,
  output logic                         eeprom_serial_data_level,
  output logic                         eeprom_serial_data_oe,
  input  wire logic                    eeprom_serial_data_sense
);
  import secl_pkg::*;

  typedef struct packed {
    secl_mstate_t   state;
    logic [2:0]     step;
    logic           host_op;
    logic           req_tgl;
    logic           ack_s1;
    logic           ack_s2;
    logic           ack_seen;
    secl_cmd_t      cmd;
    logic           ready;
    secl_host_rsp_t rsp;
    secl_cfg_t      cfg;
    logic           wp;
    logic           wp_pin;
  } secl_main_st_t;

  secl_main_st_t      st_r;
  secl_main_st_t      st_nxt;
  logic               link_ack;
  logic [15:0]        link_rdata;
  logic [SECL_AW-1:0] acc_idx;
  logic [1:0]         acc_sub;
  logic               acc_take;
  logic               ack_edge;

  // Host word index and the sub-mask of its region
  assign acc_idx = secl_word_index(host_req.addr);
  assign acc_sub = st_r.cfg.mask[{acc_idx[SECL_AW-1 -: 3], 1'b0} +: 2];
  assign acc_take = host_req.valid && st_r.ready;
  // Only the second sync stage is looked at
  assign ack_edge = st_r.ack_s2 != st_r.ack_seen;

  // Sequencer: signature, then mask and configuration words if it matches, then host service
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_s1 = link_ack;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.rsp.ack = 1'b0;
    st_nxt.rsp.denied = 1'b0;
    st_nxt.wp_pin = wp_gpio_sel ? gpio_level : st_r.wp;
    case (st_r.state)
      SECL_M_START: begin
        st_nxt.step = SECL_STEP_SIG;
        st_nxt.state = SECL_M_ISSUE;
      end
      SECL_M_ISSUE: begin
        st_nxt.cmd.we = 1'b0;
        st_nxt.cmd.wdata = 16'h0;
        if (st_r.step == SECL_STEP_SIG) begin
          st_nxt.cmd.addr = secl_word_index(SECL_SIG_OFFSET);
        end else if (st_r.step == SECL_STEP_MASK) begin
          st_nxt.cmd.addr = secl_word_index(SECL_MASK_OFFSET);
        end else begin
          st_nxt.cmd.addr = SECL_CFG_BASE +
            {5'h0, st_r.step - SECL_STEP_CFG0};
        end
        st_nxt.req_tgl = ~st_r.req_tgl;
        st_nxt.state = SECL_M_WAIT;
      end
      SECL_M_WAIT: begin
        if (ack_edge) begin
          st_nxt.ack_seen = st_r.ack_s2;
          if (st_r.host_op) begin
            st_nxt.host_op = 1'b0;
            st_nxt.rsp.ack = 1'b1;
            st_nxt.rsp.rdata = st_r.cmd.we ? 32'h0 : {16'h0, link_rdata};
            st_nxt.wp = 1'b1;
            st_nxt.ready = 1'b1;
            st_nxt.state = SECL_M_READY;
          end else begin
            case (st_r.step)
              SECL_STEP_SIG: begin
                if (link_rdata == SECL_SIGNATURE) begin
                  st_nxt.cfg.sig_ok = 1'b1;
                  st_nxt.cfg.present = 1'b1;
                  st_nxt.step = SECL_STEP_MASK;
                  st_nxt.state = SECL_M_ISSUE;
                end else begin
                  st_nxt.cfg.present = link_rdata != SECL_BLANK_WORD;
                  st_nxt.cfg.mask = SECL_MASK_DEFAULT;
                  st_nxt.cfg.words = SECL_CFG_DEFAULT;
                  st_nxt.cfg.valid = 1'b1;
                  st_nxt.ready = 1'b1;
                  st_nxt.state = SECL_M_READY;
                end
              end
              SECL_STEP_MASK: begin
                st_nxt.cfg.mask = link_rdata;
                st_nxt.step = SECL_STEP_CFG0;
                st_nxt.state = SECL_M_ISSUE;
              end
              default: begin
                st_nxt.cfg.words[2'(st_r.step - SECL_STEP_CFG0)] = link_rdata;
                if (st_r.step == SECL_STEP_LAST) begin
                  st_nxt.cfg.valid = 1'b1;
                  st_nxt.ready = 1'b1;
                  st_nxt.state = SECL_M_READY;
                end else begin
                  st_nxt.step = st_r.step + 3'h1;
                  st_nxt.state = SECL_M_ISSUE;
                end
              end
            endcase
          end
        end
      end
      SECL_M_READY: begin
        if (acc_take) begin
          if (!secl_allowed(st_r.cfg.mask, acc_idx, host_req.we)) begin
            st_nxt.rsp.ack = 1'b1;
            st_nxt.rsp.denied = 1'b1;
            st_nxt.rsp.rdata = 32'h0;
          end else begin
            st_nxt.cmd.we = host_req.we;
            st_nxt.cmd.addr = acc_idx;
            st_nxt.cmd.wdata = host_req.wdata[15:0];
            st_nxt.wp = !host_req.we;
            st_nxt.req_tgl = ~st_r.req_tgl;
            st_nxt.host_op = 1'b1;
            st_nxt.ready = 1'b0;
            st_nxt.state = SECL_M_WAIT;
          end
        end
      end
      default: st_nxt.state = SECL_M_START;
    endcase
  end

  // State register; part stays write protected out of reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.wp <= 1'b1;
      st_r.wp_pin <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  secl_link u_link (
    .link_clk                 (link_clk),
    .sys_rst                  (sys_rst),
    .cmd                      (st_r.cmd),
    .req_tgl                  (st_r.req_tgl),
    .ack_tgl                  (link_ack),
    .rdata                    (link_rdata),
    .eeprom_serial_clock      (eeprom_serial_clock),
    .eeprom_serial_data_level (eeprom_serial_data_level),
    .eeprom_serial_data_oe    (eeprom_serial_data_oe),
    .eeprom_serial_data_sense (eeprom_serial_data_sense)
  );

  // Outputs straight from the state register
  assign host_ready = st_r.ready;
  assign host_rsp = st_r.rsp;
  assign cfg = st_r.cfg;
  assign eeprom_write_protect = st_r.wp_pin;

  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_ready_loaded;
    st_r.ready |-> st_r.cfg.valid && st_r.state == SECL_M_READY;
  endproperty
  a_ready_loaded: assert property (p_ready_loaded)
    else $error("host served before load done");

  property p_hold_load;
    !st_r.cfg.valid |-> !st_r.rsp.ack ##1 !st_r.rsp.ack;
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("host answered during load");

  property p_first_sig;
    $changed(st_r.req_tgl) && !st_r.host_op &&
      st_r.step == SECL_STEP_SIG
      |-> st_r.cmd.addr == secl_word_index(SECL_SIG_OFFSET) &&
          !st_r.cmd.we;
  endproperty
  a_first_sig: assert property (p_first_sig)
    else $error("first read not at signature word");

  property p_mask_addr;
    $changed(st_r.req_tgl) && !st_r.host_op &&
      st_r.step == SECL_STEP_MASK
      |-> st_r.cmd.addr == secl_word_index(SECL_MASK_OFFSET);
  endproperty
  a_mask_addr: assert property (p_mask_addr)
    else $error("mask read at wrong word");

  property p_defaults;
    st_r.cfg.valid && !st_r.cfg.sig_ok
      |-> st_r.cfg.words == SECL_CFG_DEFAULT &&
          st_r.cfg.mask == SECL_MASK_DEFAULT;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults not loaded without signature");

  property p_deny_zero;
    st_r.rsp.denied |-> st_r.rsp.ack && st_r.rsp.rdata == 32'h0;
  endproperty
  a_deny_zero: assert property (p_deny_zero)
    else $error("blocked read returned data");

  property p_deny_quiet;
    st_r.rsp.denied |-> $stable(st_r.req_tgl) && st_r.ready;
  endproperty
  a_deny_quiet: assert property (p_deny_quiet)
    else $error("blocked access reached the part");

  property p_none;
    acc_take && acc_sub == 2'b11 |=> st_r.rsp.denied;
  endproperty
  a_none: assert property (p_none)
    else $error("access to closed region not refused");

  property p_ro_write;
    acc_take && acc_sub == 2'b10 && host_req.we |=> st_r.rsp.denied;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to read-only region not refused");

  property p_wo_read;
    acc_take && acc_sub == 2'b01 && !host_req.we |=> st_r.rsp.denied;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("read of write-only region not refused");

  property p_index;
    acc_take && acc_sub == 2'b00
      |=> !st_r.rsp.denied && $changed(st_r.req_tgl) &&
          st_r.cmd.addr == $past(acc_idx);
  endproperty
  a_index: assert property (p_index)
    else $error("host word index wrong");

  property p_wp_write;
    st_r.host_op && st_r.cmd.we |-> !st_r.wp;
  endproperty
  a_wp_write: assert property (p_wp_write)
    else $error("protect held during host write");

  property p_wp_pin;
    !wp_gpio_sel ##1 !wp_gpio_sel |-> st_r.wp_pin == $past(st_r.wp);
  endproperty
  a_wp_pin: assert property (p_wp_pin)
    else $error("protect pin does not follow control");

  property p_load_good;
    st_r.cfg.valid && st_r.cfg.sig_ok;
  endproperty
  c_load_good: cover property (p_load_good);

  property p_load_blank;
    st_r.cfg.valid && !st_r.cfg.sig_ok;
  endproperty
  c_load_blank: cover property (p_load_blank);

  property p_denied;
    st_r.rsp.denied;
  endproperty
  c_denied: cover property (p_denied);

endmodule

// [sim/secl_part_model.sv]
`timescale 1ns/10ps
// Behavioural serial part: 256 words of 16 bits, 26-bit frames
module secl_part_model (
  input  wire logic eeprom_serial_clock,
  input  wire logic line_level,
  output logic      part_oe,
  output logic      part_bit
);
  logic [15:0] mem [256];
  logic        present = 1'b1; // Cleared to model an empty socket
  realtime     dly = 1.0;      // Raised to answer late within the bit
  int          n = 0;
  logic        rd;
  logic [7:0]  a;
  logic [15:0] sh;

  initial part_oe = 1'b0;
  initial part_bit = 1'b1;

  // frame bits are taken on the rising clock
  always @(posedge eeprom_serial_clock) begin
    if (n == 1)
      rd = line_level;
    if (n >= 2 && n <= 9)
      a = {a[6:0], line_level};
    if (n >= 10)
      sh = {sh[14:0], line_level};
    if (n == 25 && !rd && present)
      mem[a] = sh;
    n = (n == 25) ? 0 : n + 1;
  end

  // Read bits leave on the falling edge that opens each bit; the line
  // is let go after the last one so the pull-up shows again
  always @(negedge eeprom_serial_clock) begin
    part_oe <= #(dly) present && rd && n >= 10;
    part_bit <= #(dly) (n >= 10) ? mem[a][25 - n] : 1'b1;
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
module tb;
  import secl_pkg::*;
  localparam logic [15:0] MASK = 16'h03e4;
  logic           mclk = 1'b0;
  logic           link_clk = 1'b0;
  logic           sys_rst = 1'b1;
  secl_host_req_t host_req = '0;
  logic           host_ready;
  secl_host_rsp_t host_rsp;
  secl_cfg_t      cfg;
  logic           wp_gpio_sel = 1'b0;
  logic           gpio_level = 1'b0;
  logic           eeprom_write_protect;
  logic           sclk;
  logic           d_level;
  logic           d_oe;
  logic           sense;
  logic           part_oe;
  logic           part_bit;
  int             fail_count = 0;
  int             n_checks = 0;
  logic [31:0]    rd;
  logic           dn;
  logic           wp_low;

  initial forever #2 mclk = ~mclk;

  // Link clock free running, phase unrelated to mclk
  initial begin
    #17.3;
    forever #62.5 link_clk = ~link_clk;
  end

  // Pulled-up data line: device first, then part, else high
  assign sense = d_oe ? d_level : (part_oe ? part_bit : 1'b1);

  secl_loader i_dut (
    .mclk                     (mclk),
    .sys_rst                  (sys_rst),
    .link_clk                 (link_clk),
    .host_req                 (host_req),
    .host_ready               (host_ready),
    .host_rsp                 (host_rsp),
    .cfg                      (cfg),
    .wp_gpio_sel              (wp_gpio_sel),
    .gpio_level               (gpio_level),
    .eeprom_write_protect     (eeprom_write_protect),
    .eeprom_serial_clock      (sclk),
    .eeprom_serial_data_level (d_level),
    .eeprom_serial_data_oe    (d_oe),
    .eeprom_serial_data_sense (sense)
  );

  secl_part_model i_part (
    .eeprom_serial_clock (sclk),
    .line_level          (sense),
    .part_oe             (part_oe),
    .part_bit            (part_bit)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Long hold so the reset also crosses into the link domain
  task automatic do_reset();
    int k;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (140) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(host_ready, 1'b0);
    k = 0;
    while (host_ready !== 1'b1 && k < 30000) begin
      @(posedge mclk);
      k++;
    end
    #1;
    chk(cfg.valid, 1'b1);
  endtask

  // One host access; request held until the edge that takes it
  task automatic acc(input logic we, input logic [15:0] ad,
                     input logic [31:0] wd);
    int k;
    @(posedge mclk);
    host_req <= '{valid: 1'b1, we: we, addr: ad, wdata: wd};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (host_ready !== 1'b1 && k < 100);
    host_req <= '0;
    wp_low = 1'b0;
    k = 0;
    // A denial answers on the taking edge itself, so look before waiting
    #1;
    while (host_rsp.ack !== 1'b1 && k < 6000) begin
      @(posedge mclk);
      #1;
      if (eeprom_write_protect === 1'b0)
        wp_low = 1'b1;
      k++;
    end
    rd = host_rsp.rdata;
    dn = host_rsp.denied;
    chk(host_rsp.ack, 1'b1);
  endtask

  // Empty socket: no signature, defaults take over
  task automatic t_blank();
    i_part.present = 1'b0;
    do_reset();
    chk(cfg.sig_ok, 1'b0);
    chk(cfg.present, 1'b0);
    chk(cfg.mask, SECL_MASK_DEFAULT);
    for (int k = 0; k < SECL_CFG_N; k++)
      chk(cfg.words[k], SECL_CFG_DEFAULT[k]);
    acc(1'b0, 16'h0014, '0);
    chk(rd, 32'h0000ffff);
  endtask

  // Shared pin shows the general purpose level when selected
  task automatic t_pin();
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk);
      wp_gpio_sel <= 1'b1;
      gpio_level <= v[0];
      repeat (3) @(posedge mclk);
      #1;
      chk(eeprom_write_protect, v[0]);
    end
    @(posedge mclk);
    wp_gpio_sel <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(eeprom_write_protect, 1'b1);
  endtask

  // Programmed part, reset again in mid-run
  task automatic t_load();
    i_part.present = 1'b1;
    for (int k = 0; k < 256; k++)
      i_part.mem[k] = 16'h3c00 + k[15:0];
    i_part.mem[0] = SECL_SIGNATURE;
    i_part.mem[4] = MASK;
    do_reset();
    chk(cfg.sig_ok, 1'b1);
    chk(cfg.present, 1'b1);
    chk(cfg.mask, MASK);
    for (int k = 0; k < SECL_CFG_N; k++)
      chk(cfg.words[k], 16'h3c01 + k[15:0]);
    acc(1'b0, SECL_SIG_OFFSET, '0);
    chk(rd, {16'h0, SECL_SIGNATURE});
    acc(1'b0, SECL_MASK_OFFSET | 16'h3, '0);
    chk(rd, {16'h0, MASK});
  endtask

  // Regions 0 to 4 tried both ways with the part answering late
  task automatic t_regions();
    logic [15:0] old;
    logic [7:0]  w;
    logic [1:0]  sub;
    i_part.dly = 40.0;
    for (int r = 0; r < 5; r++) begin
      w = {r[2:0], 5'h09};
      sub = MASK[2*r +: 2];
      old = i_part.mem[w];
      acc(1'b0, {6'h0, w, r[1:0]}, '0);
      chk(dn, sub[0]);
      chk(rd, sub[0] ? 32'h0 : {16'h0, old});
      acc(1'b1, {6'h0, w, 2'h0}, {16'hbeef, 16'h7100 + r[15:0]});
      chk(dn, sub[1]);
      chk(wp_low, !sub[1]);
      chk(i_part.mem[w], sub[1] ? old : 16'h7100 + r[15:0]);
    end
  endtask

  initial begin
    t_blank();
    t_pin();
    t_load();
    t_regions();
    results();
  end

  // Run needs about 180 us; a hang ends it as a failure
  initial begin
    #300000;
    fail_count++;
    results();
  end
endmodule
